/* File: pkg/sstx_pkg.sv */
package sstx_pkg;
    // ========================================================
    // Register byte offsets
    localparam logic [11:0] OFS_TX_PTR = 12'h0544;
    localparam logic [11:0] OFS_TX_MAX = 12'h0548;
    localparam logic [11:0] OFS_TX_CNT = 12'h054C;
    localparam logic [11:0] OFS_LIST = 12'h0550;
    localparam logic [11:0] OFS_CFG = 12'h0554;
    localparam logic [11:0] OFS_IGN_CHAR = 12'h055C;
    localparam logic [11:0] OFS_ORC_CHAR = 12'h05C0;
    localparam logic [11:0] OFS_GRANT = 12'h0560;
    // ========================================================
    // Field positions and limits
    localparam int CFG_ORDER_BIT = 0;
    localparam int CFG_CPHA_BIT = 1;
    localparam int CFG_CPOL_BIT = 2;
    localparam logic [9:0] CNT_LIMIT = 10'h03FF;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_CHAR = 8'h00;
    localparam int BYTE_BITS = 8;
    localparam int SYNC_STAGES = 2;
endpackage : sstx_pkg

/* File: logic/sstx_sync.sv */
`timescale 1ns/1ps
module sstx_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    // Only the second stage reads the first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : sstx_sync

/* File: logic/sstx_buf.sv */
`timescale 1ns/1ps
module sstx_buf #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [2];
    logic [1:0] cnt_q;
    logic rd_q;
    logic wr_q;
    logic push;
    logic pop;
    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 2'd0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else if (flush) begin
            cnt_q <= 2'd0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : sstx_buf

/* File: logic/sstx_top.sv */
`timescale 1ns/1ps
module sstx_top
    import sstx_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [31:0] DMA_ADDR,
    output logic DMA_REQ,
    input wire logic DMA_ACK,
    input wire logic [7:0] DMA_DATA,
    input wire logic SCK,
    input wire logic CSN,
    output logic MISO_O,
    output logic MISO_OE
);
    // ========================================================
    // Registers
    logic [31:0] tx_buffer_pointer_q;
    logic [9:0] tx_buffer_max_bytes_q;
    logic [9:0] tx_byte_count_q;
    logic dma_list_type_q;
    logic [2:0] frame_format_config_q;
    logic [7:0] ignored_fill_char_q;
    logic [7:0] overread_fill_char_q;
    logic granted_q;
    logic wr_en;
    logic rd_en;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;
    // ========================================================
    // Link inputs
    logic sck_s;
    logic csn_s;
    logic cs_act_s;
    logic sck_prev_q;
    logic csn_prev_q;
    sstx_sync u_sync_sck (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .din(SCK),
        .dout(sck_s)
    );
    sstx_sync u_sync_csn (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .din(!CSN),
        .dout(cs_act_s)
    );
    // Synchronised active high so reset reads as idle, not as a false frame
    assign csn_s = !cs_act_s;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sck_prev_q <= 1'b0;
            csn_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            csn_prev_q <= csn_s;
        end
    end
    logic frame_start;
    logic frame_end;
    logic in_frame;
    logic sck_rise;
    logic sck_fall;
    logic lead_edge;
    logic trail_edge;
    logic shift_edge;
    assign frame_start = csn_prev_q && !csn_s;
    assign frame_end = !csn_prev_q && csn_s;
    assign in_frame = !csn_s;
    assign sck_rise = in_frame && !sck_prev_q && sck_s;
    assign sck_fall = in_frame && sck_prev_q && !sck_s;
    // Idle level follows polarity; leading edge leaves idle
    assign lead_edge = frame_format_config_q[CFG_CPOL_BIT] ? sck_fall : sck_rise;
    assign trail_edge = frame_format_config_q[CFG_CPOL_BIT] ? sck_rise : sck_fall;
    // Phase 0 shifts on trailing edge, phase 1 on leading
    assign shift_edge = frame_format_config_q[CFG_CPHA_BIT] ? lead_edge : trail_edge;
    logic sample_edge;
    // Master samples on the edge opposite the shift edge
    assign sample_edge = frame_format_config_q[CFG_CPHA_BIT] ? trail_edge : lead_edge;
    // ========================================================
    // Fetch side: DMA into two-entry buffer
    logic [9:0] fetched_q;
    logic fetch_done;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [7:0] buf_out_data;
    logic buf_pop;
    logic sess_grant_q;
    // Fetch stops at the programmed maximum
    assign fetch_done = (fetched_q >= tx_buffer_max_bytes_q);
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            DMA_REQ <= 1'b0;
            DMA_ADDR <= RST_WORD;
            fetched_q <= 10'd0;
        end else if (frame_start) begin
            DMA_REQ <= 1'b0;
            DMA_ADDR <= tx_buffer_pointer_q;
            fetched_q <= 10'd0;
        end else if (DMA_REQ) begin
            if (DMA_ACK) begin
                DMA_REQ <= 1'b0;
                DMA_ADDR <= DMA_ADDR + 32'h0000_0001;
                fetched_q <= fetched_q + 10'd1;
            end
        end else if (in_frame && sess_grant_q && !fetch_done && buf_in_ready) begin
            DMA_REQ <= 1'b1;
        end
    end
    sstx_buf #(
        .W(BYTE_BITS)
    ) u_buf (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .flush(frame_start),
        .in_valid(DMA_REQ && DMA_ACK),
        .in_ready(buf_in_ready),
        .in_data(DMA_DATA),
        .out_valid(buf_out_valid),
        .out_ready(buf_pop),
        .out_data(buf_out_data)
    );
    // ========================================================
    // Shift side
    logic [7:0] shreg_q;
    logic [2:0] bitcnt_q;
    logic [9:0] sent_q;
    logic need_load_q;
    logic [7:0] next_byte;
    logic over_read;
    assign over_read = (sent_q >= tx_buffer_max_bytes_q);
    always_comb begin
        if (!sess_grant_q) begin
            next_byte = ignored_fill_char_q;
        end else if (over_read) begin
            next_byte = overread_fill_char_q;
        end else if (buf_out_valid) begin
            next_byte = buf_out_data;
        end else begin
            next_byte = overread_fill_char_q;
        end
    end
    assign buf_pop = need_load_q && sess_grant_q && !over_read && buf_out_valid;
    logic bit_out;
    logic load_now;
    // Bit picked by order field
    assign bit_out = frame_format_config_q[CFG_ORDER_BIT] ? shreg_q[0] : shreg_q[7];
    // Waits for fetched data; an underflow falls back at the leading edge
    assign load_now = need_load_q && in_frame
        && (buf_pop || !sess_grant_q || over_read || lead_edge);
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sess_grant_q <= 1'b0;
            shreg_q <= RST_CHAR;
            bitcnt_q <= 3'd0;
            sent_q <= 10'd0;
            need_load_q <= 1'b0;
        end else if (frame_start) begin
            sess_grant_q <= granted_q;
            bitcnt_q <= 3'd0;
            sent_q <= 10'd0;
            need_load_q <= 1'b1;
        end else begin
            if (load_now) begin
                // Load the next character before its first bit leaves
                shreg_q <= next_byte;
                need_load_q <= 1'b0;
            end else if (shift_edge && !need_load_q && bitcnt_q != 3'd0) begin
                // A fresh character's first edge only presents its first bit
                shreg_q <= frame_format_config_q[CFG_ORDER_BIT] ?
                    {1'b0, shreg_q[7:1]} : {shreg_q[6:0], 1'b0};
            end
            // Eight samples by the master close a character in either phase
            if (sample_edge) begin
                if (bitcnt_q == 3'd7) begin
                    bitcnt_q <= 3'd0;
                    if (sent_q != CNT_LIMIT) begin
                        sent_q <= sent_q + 10'd1;
                    end
                    need_load_q <= 1'b1;
                end else begin
                    bitcnt_q <= bitcnt_q + 3'd1;
                end
            end
        end
    end
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            MISO_O <= 1'b0;
            MISO_OE <= 1'b0;
        end else begin
            MISO_OE <= in_frame && !need_load_q;
            MISO_O <= bit_out;
        end
    end
    // ========================================================
    // Transaction close: count capture and list advance
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_byte_count_q <= 10'd0;
        end else if (frame_end && sess_grant_q) begin
            // Counted bytes that went out, capped by the number of bytes fetched
            tx_byte_count_q <= (fetched_q < sent_q) ? fetched_q : sent_q;
        end
    end
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_buffer_pointer_q <= RST_WORD;
        end else if (wr_en && PADDR == OFS_TX_PTR) begin
            tx_buffer_pointer_q <= PWDATA;
        end else if (frame_end && sess_grant_q && dma_list_type_q) begin
            tx_buffer_pointer_q <= tx_buffer_pointer_q
                + {22'd0, tx_buffer_max_bytes_q};
        end
    end
    // ========================================================
    // APB write side
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_buffer_max_bytes_q <= 10'd0;
            dma_list_type_q <= 1'b0;
            frame_format_config_q <= 3'd0;
            ignored_fill_char_q <= RST_CHAR;
            overread_fill_char_q <= RST_CHAR;
            granted_q <= 1'b0;
        end else if (wr_en) begin
            case (PADDR)
                OFS_TX_MAX: tx_buffer_max_bytes_q <= PWDATA[9:0];
                OFS_LIST: dma_list_type_q <= PWDATA[0];
                OFS_CFG: frame_format_config_q <= PWDATA[2:0];
                OFS_IGN_CHAR: ignored_fill_char_q <= PWDATA[7:0];
                OFS_ORC_CHAR: overread_fill_char_q <= PWDATA[7:0];
                OFS_GRANT: granted_q <= PWDATA[0];
                default: granted_q <= granted_q;
            endcase
        end
    end
    // ========================================================
    // APB read side, zero wait states
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= RST_WORD;
            PSLVERR <= 1'b0;
            PREADY <= 1'b0;
        end else begin
            PREADY <= 1'b1;
            PSLVERR <= 1'b0;
            if (PSEL && !PENABLE && !PWRITE) begin
                case (PADDR)
                    OFS_TX_PTR: PRDATA <= tx_buffer_pointer_q;
                    OFS_TX_MAX: PRDATA <= {22'd0, tx_buffer_max_bytes_q};
                    OFS_TX_CNT: PRDATA <= {22'd0, tx_byte_count_q};
                    OFS_LIST: PRDATA <= {31'd0, dma_list_type_q};
                    OFS_CFG: PRDATA <= {29'd0, frame_format_config_q};
                    OFS_IGN_CHAR: PRDATA <= {24'd0, ignored_fill_char_q};
                    OFS_ORC_CHAR: PRDATA <= {24'd0, overread_fill_char_q};
                    OFS_GRANT: PRDATA <= {31'd0, granted_q};
                    default: PRDATA <= RST_WORD;
                endcase
            end
        end
    end
    // ========================================================
    // Checks
    a_count_cap: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (frame_end && sess_grant_q)
        |=> tx_byte_count_q <= $past(tx_buffer_max_bytes_q)
            && tx_byte_count_q <= $past(sent_q))
        else $error("count out of range");
    a_fetch_limit: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (DMA_REQ && DMA_ACK) |-> fetched_q < tx_buffer_max_bytes_q)
        else $error("fetch beyond maximum");
    a_ignored_char: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (need_load_q && in_frame && !sess_grant_q && !frame_start)
        |=> shreg_q == $past(ignored_fill_char_q))
        else $error("ignored fill not loaded");
    a_overread_char: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (need_load_q && in_frame && sess_grant_q && over_read && !frame_start)
        |=> shreg_q == $past(overread_fill_char_q))
        else $error("over-read fill not loaded");
    a_order_bit: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (load_now && !frame_start)
        |-> ##2 MISO_O == ($past(frame_format_config_q[CFG_ORDER_BIT], 2)
            ? $past(next_byte[0], 2) : $past(next_byte[7], 2)))
        else $error("wrong first bit after load");
    a_list_advance: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (frame_end && sess_grant_q && dma_list_type_q && !wr_en)
        |=> tx_buffer_pointer_q == $past(tx_buffer_pointer_q)
            + {22'd0, $past(tx_buffer_max_bytes_q)})
        else $error("list pointer not advanced");
    a_shift_edge: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (sample_edge && !frame_start && !load_now && bitcnt_q != 3'd7)
        |=> $stable(shreg_q) && bitcnt_q == $past(bitcnt_q) + 3'd1)
        else $error("data moved on sampling edge");
    a_apb_ready: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (PSEL && !PENABLE) |=> PREADY && !PSLVERR)
        else $error("apb not ready");
endmodule : sstx_top

/* File: bench/sstx_spim.sv */
`timescale 1ns/1ps
module sstx_spim (
    input wire logic clk,
    input wire logic miso,
    input wire logic miso_oe,
    output logic sck,
    output logic cs_n
);
    // ====================
    // Serial master, half period of 16 core clocks
    logic [7:0] rx_q[$];
    int oe_bad;
    initial begin
        sck = 1'h0;
        cs_n = 1'h1;
        oe_bad = 0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold
    // Settled long before the edge, so sampling here cannot race
    task automatic grab(inout logic [7:0] b);
        b = {b[6:0], miso};
        if (miso_oe !== 1'h1) oe_bad++;
    endtask : grab
    task automatic frame(input int n, input logic pol, input logic pha);
        logic [7:0] b;
        b = 8'h00;
        sck <= pol; // Clock stands at its idle level outside frames
        hold(2);
        cs_n <= 1'h0;
        hold(32);
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 8; k++) begin
                if (!pha) grab(b);
                sck <= !pol;
                hold(16);
                if (pha) grab(b);
                sck <= pol;
                hold(16);
            end
            rx_q.push_back(b);
        end
        hold(32);
        cs_n <= 1'h1;
        hold(64);
    endtask : frame
endmodule : sstx_spim

/* File: bench/sstx_top_tb_top.sv */
`timescale 1ns/1ps
module sstx_top_tb_top
    import sstx_pkg::*;
;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, dma_addr;
    logic dma_req, dma_ack, sck, cs_n, miso_o, miso_oe;
    logic [7:0] dma_data;
    int error_cnt = 0;
    int n_tests = 0;
    int dma_n = 0;
    sstx_top i_sstx_top (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .DMA_ADDR(dma_addr), .DMA_REQ(dma_req),
        .DMA_ACK(dma_ack), .DMA_DATA(dma_data), .SCK(sck), .CSN(cs_n),
        .MISO_O(miso_o), .MISO_OE(miso_oe));
    sstx_spim i_sstx_spim (.clk(clk), .miso(miso_o), .miso_oe(miso_oe), .sck(sck),
        .cs_n(cs_n));
    always #2.5 clk = !clk;
    function automatic logic [7:0] mem(input logic [31:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction : mem
    function automatic logic [7:0] on_wire(input logic [7:0] b, input logic lsb);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = lsb ? b[7-i] : b[i];
        return r;
    endfunction : on_wire
    // ====================
    // Memory side answers each fetch one cycle later
    always @(posedge clk) begin
        dma_ack <= dma_req && !dma_ack; // Buffer sits in reachable memory
        dma_data <= mem(dma_addr);
        if (dma_req && dma_ack) dma_n++;
    end
    // ====================
    // Checks and bus cycles
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // Only the watchdog ends a transfer that never completes
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        q = prdata;
        cmp_byte({7'h0, pslverr}, 8'h00);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'h1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'h0, a, 32'h0000_0000, q);
        cmp_word(q, e);
    endtask : rd_chk
    task automatic setup(input logic [31:0] p, input logic [31:0] m, input logic g,
        input logic l, input logic [2:0] c);
        wr(OFS_GRANT, {31'h0, g});
        wr(OFS_LIST, {31'h0, l});
        wr(OFS_TX_PTR, p);
        wr(OFS_TX_MAX, m);
        wr(OFS_CFG, {29'h0, c});
    endtask : setup
    // ====================
    // Scenarios
    task automatic t_reset();
        rd_chk(OFS_TX_PTR, RST_WORD);
        rd_chk(OFS_TX_MAX, RST_WORD);
        rd_chk(OFS_TX_CNT, RST_WORD);
        rd_chk(OFS_LIST, RST_WORD);
        rd_chk(OFS_CFG, RST_WORD);
        rd_chk(OFS_IGN_CHAR, RST_WORD);
        rd_chk(OFS_ORC_CHAR, RST_WORD);
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs();
        setup(32'h1234_5678, 32'h0000_03FF, 1'h0, 1'h1, 3'h7);
        wr(OFS_TX_CNT, 32'h0000_0077);
        wr(12'h0600, 32'h0000_0055);
        rd_chk(OFS_TX_PTR, 32'h1234_5678);
        rd_chk(OFS_TX_MAX, 32'h0000_03FF);
        rd_chk(OFS_LIST, 32'h0000_0001);
        rd_chk(OFS_CFG, 32'h0000_0007);
        rd_chk(OFS_TX_CNT, RST_WORD);
        rd_chk(12'h0600, RST_WORD);
        $display("test registers done");
    endtask : t_regs
    // n bytes against a limit of three, so with five bytes the tail is over-read
    task automatic t_frame(input logic [2:0] c, input int n);
        logic [7:0] e;
        setup(32'h0000_0100, 32'h0000_0003, 1'h1, 1'h0, c);
        wr(OFS_ORC_CHAR, 32'h0000_00C3);
        dma_n = 0;
        i_sstx_spim.frame(n, c[CFG_CPOL_BIT], c[CFG_CPHA_BIT]);
        for (int i = 0; i < n; i++) begin
            e = (i < 3) ? mem(32'h0000_0100 + i) : 8'hC3;
            cmp_byte(i_sstx_spim.rx_q.pop_front(), on_wire(e, c[0]));
        end
        cmp_word({31'h0, dma_n <= 3}, 32'h0000_0001);
        rd_chk(OFS_TX_CNT, (n < 3) ? n : 3);
        $display("test frame cfg %0d bytes %0d done", c, n);
    endtask : t_frame
    task automatic t_ignored();
        setup(32'h0000_0100, 32'h0000_0003, 1'h0, 1'h0, 3'h0);
        wr(OFS_IGN_CHAR, 32'h0000_003C);
        i_sstx_spim.frame(2, 1'h0, 1'h0);
        for (int i = 0; i < 2; i++) begin
            cmp_byte(i_sstx_spim.rx_q.pop_front(), 8'h3C);
        end
        rd_chk(OFS_TX_CNT, 32'h0000_0002);
        $display("test ignored done");
    endtask : t_ignored
    task automatic t_list();
        setup(32'h0000_0200, 32'h0000_0002, 1'h1, 1'h1, 3'h0);
        for (int j = 0; j < 2; j++) begin
            i_sstx_spim.frame(2, 1'h0, 1'h0);
            for (int i = 0; i < 2; i++) begin
                cmp_byte(i_sstx_spim.rx_q.pop_front(), mem(32'h0200 + 2 * j + i));
            end
            rd_chk(OFS_TX_PTR, 32'h0000_0202 + 2 * j);
        end
        cmp_word(i_sstx_spim.oe_bad, 32'h0000_0000);
        $display("test list done");
    endtask : t_list
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    // ====================
    // Main sequence and watchdog
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        clk = 1'h0;
        rstn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        t_reset();
        t_regs();
        for (int c = 0; c < 8; c++) t_frame(c[2:0], 5);
        t_frame(3'h0, 2);
        t_ignored();
        t_list();
        finish_test();
    end
endmodule : sstx_top_tb_top
